// file: hdl/ppm_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH
`define OFS_DATA 12'h000
`define OFS_STATUS 12'h001
`define OFS_CTRL 12'h002
`define OFS_FIFO 12'h400
`define OFS_CFGB 12'h401
`define OFS_ECR 12'h402
`define ECR_MODE_HI 7
`define ECR_MODE_LO 5
`define ECR_RESET 8'h15
`define CTRL_RESET 6'h00
`define CFGA_VALUE 8'h10
`define CFGB_VALUE 8'h00
`define STEP_NS 500
`define STEP_CYC ((`STEP_NS + 39) / 40)
`endif

// file: hdl/ppm_pkg.sv
// types shared by the parallel port mode control
package ppm_pkg;
  typedef enum logic [2:0] {
    MODE_STD = 3'h0,
    MODE_BIDIR = 3'h1,
    MODE_FIFO = 3'h2,
    MODE_ECP = 3'h3,
    MODE_EPP = 3'h4,
    MODE_RSVD = 3'h5,
    MODE_TEST = 3'h6,
    MODE_CFG = 3'h7
  } port_mode_e;
endpackage

// file: hdl/ppm_port.sv
// multi-mode parallel port: mode control, byte fifo and handshakes
// Notes on behaviour
// - empty status bit reads 1 with fifo empty, 0 otherwise
// - mode 000: fifo held in reset, control drivers open-drain
// - mode 001: direction tri-states data; data reads return pin levels
// - mode 010: fifo bytes sent with compatibility handshake, forward only
// - mode 011: command and data share fifo; reverse fills fifo
// - mode 100 selects epp only with epp option enabled; push-pull
// - mode 110 tests fifo without handshake; code 101 reserved
// - mode 111: config registers at 0x400 and 0x401 replace fifo
// - automatic handshake runs only in modes 011 and 010
// - leaving forward extended mode deasserts all handshake lines on the same edge that changes the mode
// - leaving ecp reverse discards bytes and deasserts auto feed
// - mode changes cause no glitches on handshake lines
// - command bytes via command port, data via fifo port at 0x400; forward only
// - ecp reverse handshakes each byte and fills the fifo until it is full, then stops requesting
// - hostack/periphack high marks data, low marks command; periphack is not sampled, reverse bytes are stored as data
// - forward command bit 7: 0 run length, 1 channel address
// - ecr bits 7:5 hold the read/write mode code
// - command port write in mode 011 forward tags byte as command
`timescale 1ns/100ps
`include "ppm_consts.svh"
module ppm_port import ppm_pkg::*; #(
  parameter int DEPTH = 16,
  parameter logic EPP_OPTION = 1'b0
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] pd_i,
  output logic [7:0] pd_o,
  output logic pd_oe_o,
  input wire logic busy_i,
  input wire logic ack_n_i,
  input wire logic fault_n_i,
  input wire logic perr_i,
  input wire logic select_i,
  output logic byte_strobe_line_n_o,
  output logic byte_strobe_line_n_oe_o,
  output logic auto_feed_line_n_o,
  output logic auto_feed_line_n_oe_o,
  output logic peripheral_reset_line_n_o,
  output logic peripheral_reset_line_n_oe_o,
  output logic peripheral_select_line_n_o,
  output logic peripheral_select_line_n_oe_o,
  output logic epp_active_o
);
  localparam int AW = $clog2(DEPTH);
  typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_WAIT} hs_e;

  logic [7:0] data_ff;
  logic [5:0] ctrl_ff;
  logic [2:0] mode_ff;
  logic [4:0] ecr_low_ff;
  logic [7:0] mem [DEPTH];
  logic [DEPTH-1:0] tag_ff;
  logic [AW-1:0] wp_ff, rp_ff;
  logic [AW:0] cnt_ff;
  logic [7:0] last_ff;
  logic [7:0] rdata_ff;
  hs_e hs_ff;
  logic [7:0] tmr_ff;
  logic [7:0] out_ff;
  logic host_ack_ff, strobe_ff, afd_ff;

  function automatic logic is_mode(input logic [2:0] m, input port_mode_e e);
    return m == e;
  endfunction

  // decode
  wire logic dir = ctrl_ff[5] && !is_mode(mode_ff, MODE_STD)
    && !is_mode(mode_ff, MODE_FIFO);
  wire logic fifo_en = !is_mode(mode_ff, MODE_STD);
  wire logic empty = cnt_ff == '0;
  wire logic full = cnt_ff == (AW+1)'(DEPTH);
  wire logic auto_mode = is_mode(mode_ff, MODE_FIFO)
    || is_mode(mode_ff, MODE_ECP);
  wire logic fwd_auto = auto_mode && !dir;
  wire logic rev_auto = is_mode(mode_ff, MODE_ECP) && dir;
  wire logic fifo_port = addr_i == `OFS_FIFO && !is_mode(mode_ff, MODE_CFG);
  wire logic cmd_wr = wr_i && addr_i == `OFS_DATA
    && is_mode(mode_ff, MODE_ECP) && !dir;
  wire logic dat_wr = wr_i && fifo_port && !dir
    && (is_mode(mode_ff, MODE_FIFO) || is_mode(mode_ff, MODE_ECP)
    || is_mode(mode_ff, MODE_TEST));
  wire logic tst_wr = wr_i && fifo_port && dir && is_mode(mode_ff, MODE_TEST);
  wire logic hs_pop = fwd_auto && hs_ff == HS_IDLE && !empty && !busy_i;
  wire logic rev_push = rev_auto && hs_ff == HS_WAIT && ack_n_i;
  wire logic cpu_pop = rd_i && fifo_port && !empty
    && (is_mode(mode_ff, MODE_ECP) && dir || is_mode(mode_ff, MODE_TEST));
  wire logic push = (cmd_wr || dat_wr || tst_wr || rev_push) && !full;
  wire logic pop = hs_pop || cpu_pop;
  wire logic push_tag = cmd_wr; // command bytes go out with hostack low
  wire logic [7:0] push_byte = rev_push ? pd_i : wdata_i;
  wire logic ecr_wr = wr_i && addr_i == `OFS_ECR;
  wire logic [2:0] new_mode = wdata_i[`ECR_MODE_HI:`ECR_MODE_LO];
  wire logic mode_chg = ecr_wr && new_mode != mode_ff;
  wire logic leave_auto = mode_chg && auto_mode;
  wire logic [7:0] status_rd = {~busy_i, ack_n_i, perr_i, select_i,
    fault_n_i, 3'h0};
  wire logic [7:0] ecr_rd = {mode_ff, ecr_low_ff[4:2], full, empty};
  wire logic [7:0] data_rd = (is_mode(mode_ff, MODE_STD)) ? data_ff
    : pd_i;
  wire logic [7:0] fifo_rd = empty ? last_ff : mem[rp_ff];
  wire logic [7:0] nxt_rdata =
    rd_i && addr_i == `OFS_DATA ? data_rd :
    rd_i && addr_i == `OFS_STATUS ? status_rd :
    rd_i && addr_i == `OFS_CTRL ? {2'h0, ctrl_ff} :
    rd_i && addr_i == `OFS_ECR ? ecr_rd :
    rd_i && addr_i == `OFS_FIFO && is_mode(mode_ff, MODE_CFG) ? `CFGA_VALUE :
    rd_i && addr_i == `OFS_CFGB && is_mode(mode_ff, MODE_CFG) ? `CFGB_VALUE :
    rd_i && fifo_port ? fifo_rd : 8'h00;

  // host registers; mode resets to standard
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_ff <= 8'h00;
      ctrl_ff <= `CTRL_RESET;
      mode_ff <= 3'h0;
      ecr_low_ff <= 5'(`ECR_RESET);
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
      if (wr_i && addr_i == `OFS_DATA && !cmd_wr) data_ff <= wdata_i;
      if (wr_i && addr_i == `OFS_CTRL) ctrl_ff <= wdata_i[5:0];
      if (ecr_wr) begin
        mode_ff <= new_mode;
        ecr_low_ff <= wdata_i[4:0];
      end
    end
  end

  // fifo; cleared in standard mode and on leaving ecp reverse (mode 011 with direction set),
  // which drops unread reverse bytes
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      last_ff <= 8'h00;
      tag_ff <= '0;
    end else if (!fifo_en || leave_auto && rev_auto) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        mem[wp_ff] <= push_byte;
        tag_ff[wp_ff] <= push_tag;
        wp_ff <= wp_ff == AW'(DEPTH - 1) ? '0 : wp_ff + 1'b1;
      end
      if (pop) begin
        last_ff <= mem[rp_ff];
        rp_ff <= rp_ff == AW'(DEPTH - 1) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // automatic handshake; a mode change forces every line inactive
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hs_ff <= HS_IDLE;
      tmr_ff <= 8'h00;
      out_ff <= 8'h00;
      host_ack_ff <= 1'b1;
      strobe_ff <= 1'b0;
      afd_ff <= 1'b0;
    end else if (!auto_mode || leave_auto) begin
      hs_ff <= HS_IDLE;
      strobe_ff <= 1'b0;
      afd_ff <= 1'b0;
      host_ack_ff <= 1'b1;
    end else begin
      unique case (hs_ff)
        HS_IDLE: begin
          if (hs_pop) begin
            out_ff <= mem[rp_ff];
            host_ack_ff <= !tag_ff[rp_ff];
            tmr_ff <= 8'(`STEP_CYC);
            hs_ff <= HS_SETUP;
          end else if (rev_auto && !full) begin
            afd_ff <= 1'b1; // ask the peripheral for a byte
            hs_ff <= HS_STROBE;
          end
        end
        HS_SETUP: begin
          if (tmr_ff == 8'h01) begin
            strobe_ff <= 1'b1;
            tmr_ff <= 8'(`STEP_CYC);
            hs_ff <= HS_STROBE;
          end else tmr_ff <= tmr_ff - 8'h01;
        end
        HS_STROBE: begin
          if (rev_auto) begin
            if (!ack_n_i) begin
              afd_ff <= 1'b0;
              hs_ff <= HS_WAIT;
            end
          end else if (tmr_ff == 8'h01) begin
            strobe_ff <= 1'b0;
            hs_ff <= HS_WAIT;
          end else tmr_ff <= tmr_ff - 8'h01;
        end
        HS_WAIT: begin
          if (rev_auto ? ack_n_i : !busy_i) hs_ff <= HS_IDLE;
        end
      endcase
    end
  end

  // pins: auto modes take over strobe, auto feed and data
  wire logic drv_ctrl_oc = is_mode(mode_ff, MODE_STD);
  wire logic strobe_lvl = auto_mode ? !strobe_ff : !ctrl_ff[0];
  wire logic afd_lvl = is_mode(mode_ff, MODE_ECP) ? (dir ? !afd_ff
    : host_ack_ff) : auto_mode ? 1'b1 : !ctrl_ff[1];
  assign byte_strobe_line_n_o = strobe_lvl;
  assign byte_strobe_line_n_oe_o = !drv_ctrl_oc || !strobe_lvl;
  assign auto_feed_line_n_o = afd_lvl;
  assign auto_feed_line_n_oe_o = !drv_ctrl_oc || !afd_lvl;
  assign peripheral_reset_line_n_o = ctrl_ff[2];
  assign peripheral_reset_line_n_oe_o = !drv_ctrl_oc || !ctrl_ff[2];
  assign peripheral_select_line_n_o = !ctrl_ff[3];
  assign peripheral_select_line_n_oe_o = !drv_ctrl_oc || ctrl_ff[3];
  assign pd_o = fwd_auto ? out_ff : is_mode(mode_ff, MODE_TEST)
    ? last_ff : data_ff;
  assign pd_oe_o = !dir;
  assign epp_active_o = is_mode(mode_ff, MODE_EPP) && EPP_OPTION;
  assign rdata_o = rdata_ff;

  empty_flag_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rd_i && addr_i == `OFS_ECR |=> rdata_o[0] == $past(cnt_ff == '0))
    else $error("empty flag mismatch");
  std_fifo_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    is_mode(mode_ff, MODE_STD) |=> cnt_ff == '0 || $past(ecr_wr))
    else $error("fifo not held in standard mode");
  std_dir_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    is_mode(mode_ff, MODE_STD) |-> pd_oe_o)
    else $error("data tri-stated in standard mode");
  leave_lines_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    leave_auto |=> !strobe_ff && !afd_ff && hs_ff == HS_IDLE)
    else $error("handshake left active after mode change");
  rev_drop_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    leave_auto && rev_auto |=> cnt_ff == '0)
    else $error("reverse bytes kept");
  auto_only_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !auto_mode |=> !strobe_ff || auto_mode)
    else $error("strobe outside automatic mode");
  test_quiet_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    is_mode(mode_ff, MODE_TEST) |-> byte_strobe_line_n_o == !ctrl_ff[0])
    else $error("handshake in test mode");
  cfg_read_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rd_i && addr_i == `OFS_FIFO && is_mode(mode_ff, MODE_CFG)
    |=> rdata_o == `CFGA_VALUE)
    else $error("config register a not returned");
  cmd_tag_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    cmd_wr && !full |=> tag_ff[$past(wp_ff)])
    else $error("command byte not tagged");
endmodule

// file: dv/ppm_periph.sv
// printer-side model: latches forward bytes, sends reverse bytes
`timescale 1ns/100ps
module ppm_periph (
  input wire logic mclk_i,
  input wire logic [7:0] host_pd_i,
  input wire logic host_oe_i,
  input wire logic strobe_n_i,
  input wire logic auto_feed_bit_n_i,
  output logic [7:0] pins_o,
  output logic busy_o,
  output logic ack_n_o
);
  logic [8:0] cap_q[$];
  logic [7:0] rev_q[$];
  logic [7:0] drv = 8'h5a;
  logic rev = 1'b0;
  logic fbusy = 1'b0;
  int lag = 0;
  int fc = 0;
  int rc = 0;
  // a released bus shows the byte being sent while rev is set, otherwise the inverse of the last byte
  assign pins_o = host_oe_i ? host_pd_i : (rev ? drv : ~drv);
  assign busy_o = fbusy | rev;
  initial ack_n_o = 1'b1;
  // forward: take byte and hostack level at strobe, then busy lag cycles
  always @(posedge mclk_i) begin
    if (!strobe_n_i && !fbusy) begin
      cap_q.push_back({auto_feed_bit_n_i, host_pd_i});
      fbusy <= 1'b1;
      fc <= lag;
    end else if (fbusy && strobe_n_i) begin
      if (fc > 0)
        fc <= fc - 1;
      else
        fbusy <= 1'b0;
    end
  end
  // reverse: byte with ack low, ack high lag cycles after autofeed rises
  always @(posedge mclk_i) begin
    if (!rev && rev_q.size() > 0 && !auto_feed_bit_n_i) begin
      drv <= rev_q.pop_front();
      rev <= 1'b1;
      ack_n_o <= 1'b0;
      rc <= 0;
    end else if (rev && !ack_n_o && auto_feed_bit_n_i) begin
      if (rc < lag)
        rc <= rc + 1;
      else
        ack_n_o <= 1'b1;
    end else if (rev && ack_n_o)
      rev <= 1'b0; // byte held one cycle past ack rising
  end
endmodule

// file: dv/ecp_parallel_port_mode_control_tb.sv
// self-checking bench for the parallel port mode control
`timescale 1ns/100ps
`include "ppm_consts.svh"
module ecp_parallel_port_mode_control_tb;
  localparam int DP = 16;
  logic mclk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0;
  logic [11:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o, pd_i, pd_o, d, s = 8'h08;
  logic pd_oe_o, busy_i, ack_n_i, sn, soe, an, aoe, epp;
  logic rn, roe, pn, poe;
  logic [8:0] c;
  int err_total = 0, n_checks = 0, q[$], i, m;
  // open-drain control lines idle high through the pull-up
  wire stb = soe ? sn : 1'b1;
  wire afd = aoe ? an : 1'b1;
  ppm_port #(.DEPTH(DP), .EPP_OPTION(1'b0)) dut_u (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pd_i(pd_i),
    .pd_o(pd_o), .pd_oe_o(pd_oe_o), .busy_i(busy_i), .ack_n_i(ack_n_i),
    .fault_n_i(1'b1), .perr_i(1'b0), .select_i(1'b1),
    .byte_strobe_line_n_o(sn), .byte_strobe_line_n_oe_o(soe),
    .auto_feed_line_n_o(an), .auto_feed_line_n_oe_o(aoe),
    .peripheral_reset_line_n_o(rn), .peripheral_reset_line_n_oe_o(roe),
    .peripheral_select_line_n_o(pn), .peripheral_select_line_n_oe_o(poe),
    .epp_active_o(epp));
  ppm_periph periph_u (.mclk_i(mclk_i), .host_pd_i(pd_o),
    .host_oe_i(pd_oe_o), .strobe_n_i(stb), .auto_feed_bit_n_i(afd),
    .pins_o(pd_i), .busy_o(busy_i), .ack_n_o(ack_n_i));
  // 25 MHz clock
  initial forever #20 mclk_i = ~mclk_i;
  function automatic logic [7:0] nx(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t byte %h want %h", $time, g, e);
    end
  endtask
  task automatic chkp(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t bit %b want %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] w);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= w;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic md(input logic [2:0] x);
    wr(`OFS_ECR, {x, 5'h14});
  endtask
  task automatic results;
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial begin
    #(40 * 40000);
    err_total++;
    results;
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd(`OFS_ECR);
    chk(d, `ECR_RESET);
    for (m = 0; m < 8; m++) begin
      md(3'h1);
      md(m[2:0]);
      rd(`OFS_ECR);
      chk({5'h0, d[7:5]}, m[7:0]);
      chkp(soe, m != 0);
      chkp(poe, m != 0);
      chkp(epp, 1'b0);
    end
    rd(`OFS_FIFO);
    chk(d, `CFGA_VALUE);
    rd(`OFS_CFGB);
    chk(d, `CFGB_VALUE);
    // test mode: overfill, drain, then one underrun read
    md(3'h1);
    md(3'h6);
    for (i = 0; i <= DP; i++) begin
      s = nx(s);
      wr(`OFS_FIFO, s);
      if (q.size() < DP) q.push_back(s);
    end
    rd(`OFS_ECR);
    chkp(d[1], 1'b1);
    for (i = 0; i < DP; i++) begin
      rd(`OFS_FIFO);
      c = 9'(q[0]);
      chk(d, 8'(q.pop_front()));
    end
    rd(`OFS_FIFO);
    chk(d, c[7:0]);
    rd(`OFS_ECR);
    chkp(d[0], 1'b1);
    chk(8'(periph_u.cap_q.size()), 8'h00);
    wr(`OFS_FIFO, s);
    rd(`OFS_ECR);
    chkp(d[0], 1'b0);
    md(3'h0);
    md(3'h6);
    rd(`OFS_ECR);
    chkp(d[0], 1'b1);
    // bidirectional read of the pins
    md(3'h0);
    md(3'h1);
    periph_u.drv <= s;
    wr(`OFS_CTRL, 8'h20);
    rd(`OFS_DATA);
    chkp(pd_oe_o, 1'b0);
    chk(d, ~s);
    // direction back to forward while still in mode 001
    wr(`OFS_CTRL, 8'h00);
    md(3'h0);
    // open-drain lines: released when high, driven only when low
    wr(`OFS_CTRL, 8'h0c);
    #1 chkp(roe, 1'b0);
    chkp(rn, 1'b1);
    chkp(poe, 1'b1);
    chkp(pn, 1'b0);
    // fifo mode with a prompt printer
    wr(`OFS_CTRL, 8'h00);
    md(3'h2);
    s = nx(s);
    wr(`OFS_FIFO, s);
    for (i = 0; i < 3000 && periph_u.cap_q.size() < 1; i++)
      @(posedge mclk_i);
    c = periph_u.cap_q.pop_front();
    chk(c[7:0], s);
    // ecp forward: command and data bytes interleaved, slow printer
    md(3'h0);
    md(3'h3);
    periph_u.lag = 20;
    for (i = 0; i < 4; i++) begin
      s = nx(s);
      if (i[0]) begin
        s[7] = i[1];
        wr(`OFS_DATA, s);
        q.push_back({1'b0, s});
      end else begin
        wr(`OFS_FIFO, s);
        q.push_back({1'b1, s});
      end
    end
    for (i = 0; i < 6000 && periph_u.cap_q.size() < 4; i++)
      @(posedge mclk_i);
    chk(8'(periph_u.cap_q.size()), 8'h04);
    while (periph_u.cap_q.size() > 0) begin
      c = periph_u.cap_q.pop_front();
      chkp(c[8], q[0][8]);
      chk(c[7:0], 8'(q.pop_front()));
    end
    // ecp reverse: four bytes in, three read, then leave mid-transfer
    md(3'h1);
    wr(`OFS_CTRL, 8'h20);
    md(3'h3);
    periph_u.lag = 2;
    // a fourth byte stays unread so that leaving reverse must drop it
    for (i = 0; i < 4; i++) begin
      s = nx(s);
      periph_u.rev_q.push_back(s);
      if (i < 3) q.push_back(s);
    end
    for (i = 0; i < 3000 && (periph_u.rev_q.size() > 0 || periph_u.rev); i++)
      @(posedge mclk_i);
    repeat (4) @(posedge mclk_i);
    for (i = 0; i < 3; i++) begin
      rd(`OFS_FIFO);
      chk(d, 8'(q.pop_front()));
    end
    rd(`OFS_ECR);
    chkp(d[0], 1'b0);
    periph_u.lag = 100;
    periph_u.rev_q.push_back(nx(s));
    for (i = 0; i < 3000 && ack_n_i; i++)
      @(posedge mclk_i);
    md(3'h1);
    @(posedge mclk_i);
    #1 chkp(afd, 1'b1);
    for (i = 0; i < 3000 && periph_u.rev; i++)
      @(posedge mclk_i);
    rd(`OFS_ECR);
    chkp(d[0], 1'b1);
    results;
  end
endmodule
